// ==== bench/tb_top.sv ====
// Self-checking bench for the CC detect and indicate block
`timescale 1ns/100ps
`include "tcc_defines.vh"

module tb_top;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       chip_enable_bar = 1'b0;
   logic       roleWrite = 1'b0;
   logic       statusAck = 1'b0;
   logic [1:0] adrStrap = `TCC_STRAP_MID;
   logic [1:0] roleStrap = `TCC_STRAP_LOW;
   logic [1:0] roleOverride = 2'h0;
   logic [1:0] rpSelect = `TCC_CUR_DEFAULT;
   logic [2:0] kind1 = 3'd0;
   logic [2:0] kind2 = 3'd0;
   wire        cc1BelowRa, cc1BelowRd, cc1AboveRp1, cc1AboveRp2;
   wire        cc2BelowRa, cc2BelowRd, cc2AboveRp1, cc2AboveRp2;
   wire        busMode, busAdrHigh, hostRole, cableAttached, attachedSink, attachedHost;
   wire        connection_detect_out, idOut, idOe_b, status_change_irq_n, irqOe_b;
   wire        audio_accessory_flag_n, audioOe_b, source_current_ind_hi, indHiOe_b;
   wire        source_current_ind_lo, indLoOe_b;
   wire [1:0]  activeRole, orientation, accessory, cc1Term, cc2Term, detectedCurrent, rpLevelSel;
   wire [2:0]  rpSourceEn;
   int         compares = 0;
   int         miscompares = 0;

   // ==========
   // Open-drain wires with board pull-ups
   wire        idLine = idOe_b | idOut;
   wire        irqLine = irqOe_b | status_change_irq_n;
   wire        audioLine = audioOe_b | audio_accessory_flag_n;
   wire [1:0]  curPins = {indHiOe_b | source_current_ind_hi, indLoOe_b | source_current_ind_lo};
   logic [1:0] pinCode [3] = '{2'h3, 2'h2, 2'h0};

   always #2.5 clk = ~clk;

   // Short toggle period; one scenario runs dual role
   tcc_cc_detect #(.TOGGLE_CYC(8)) tcc_cc_detect_inst (.*);
   tcc_remote_port tcc_remote_port_inst (.*);

   // ==========
   // Bench tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Straps are only sampled after release, so set them under reset
   task automatic power_up(input logic [1:0] adr, input logic [1:0] role);
      rst_b = 1'b0;
      adrStrap = adr;
      roleStrap = role;
      kind1 = 3'd0;
      kind2 = 3'd0;
      tick(20);
      rst_b = 1'b1;
      tick(24);
   endtask

   task automatic attach(input logic [2:0] k1, input logic [2:0] k2);
      kind1 = k1;
      kind2 = k2;
      tick(8);
   endtask

   // One-cycle strobe: role write when wr, status acknowledge otherwise
   task automatic strobe(input logic wr);
      if (wr)
         roleWrite = 1'b1;
      else
         statusAck = 1'b1;
      tick(1);
      roleWrite = 1'b0;
      statusAck = 1'b0;
      tick(6);
   endtask

   task automatic test_done;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========
   // Scenarios
   initial begin
      // Pin mode as sink: every advertised level on CC1
      power_up(`TCC_STRAP_MID, `TCC_STRAP_LOW);
      chk(busMode, 1'b0);
      for (int i = 0; i < 3; i++) begin
         attach(3'(3 + i), 3'd0);
         chk(detectedCurrent, 8'(i));
         chk(curPins, pinCode[i]);
         chk({connection_detect_out, attachedHost, orientation}, {2'b11, `TCC_ORIENT_CC1});
      end
      attach(3'd0, 3'd5);
      chk({orientation, curPins}, {`TCC_ORIENT_CC2, 2'h0});
      attach(3'd0, 3'd0);
      chk({connection_detect_out, cableAttached, curPins}, 4'h3);
      // Live strap change to host, then sink and accessories
      roleStrap = `TCC_STRAP_HIGH;
      tick(4);
      chk({activeRole, hostRole, rpSourceEn}, {`TCC_ROLE_HOST, 1'b1, 3'h1});
      attach(3'd0, 3'd2);
      chk({idLine, attachedSink, orientation, cc2Term}, {2'b01, `TCC_ORIENT_CC2, `TCC_TERM_RD});
      attach(3'd1, 3'd1);
      chk({audioLine, accessory}, {1'b0, `TCC_ACC_AUDIO});
      attach(3'd2, 3'd2);
      chk({audioLine, accessory}, {1'b1, `TCC_ACC_DEBUG});
      attach(3'd1, 3'd0);
      chk({cc1Term, cc2Term}, {`TCC_TERM_RA, `TCC_TERM_OPEN});
      roleStrap = `TCC_STRAP_MID;
      tick(12);
      chk({activeRole, hostRole}, {`TCC_ROLE_DUAL, 1'b1});
      // Bus mode, high address, host strap
      power_up(`TCC_STRAP_HIGH, `TCC_STRAP_HIGH);
      chk({busMode, busAdrHigh, activeRole, rpSourceEn}, {2'b11, `TCC_ROLE_HOST, 3'h1});
      rpSelect = `TCC_CUR_MEDIUM;
      tick(4);
      chk(rpSourceEn, 3'h2);
      rpSelect = `TCC_CUR_HIGH;
      tick(4);
      chk(rpSourceEn, 3'h4);
      roleStrap = `TCC_STRAP_LOW;
      tick(4);
      chk(activeRole, `TCC_ROLE_HOST);
      roleOverride = 2'h3;
      strobe(1'b1);
      chk(activeRole, `TCC_ROLE_HOST);
      roleOverride = `TCC_ROLE_SINK;
      strobe(1'b1);
      chk({activeRole, hostRole}, {`TCC_ROLE_SINK, 1'b0});
      strobe(1'b0);
      attach(3'd4, 3'd0);
      chk({irqLine, curPins, detectedCurrent}, {3'b011, `TCC_CUR_MEDIUM});
      strobe(1'b0);
      chk(irqLine, 1'b1);
      attach(3'd5, 3'd0);
      chk(irqLine, 1'b0);
      strobe(1'b0);
      attach(3'd0, 3'd0);
      chk({irqLine, cableAttached}, 2'b00);
      // Hibernation drops pending and written state
      chip_enable_bar = 1'b1;
      tick(2);
      chk({busMode, activeRole, irqLine}, {1'b0, `TCC_ROLE_RESET, 1'b1});
      chip_enable_bar = 1'b0;
      tick(2);
      test_done();
   end

   // Whole run is about 250 cycles; this leaves ample margin
   initial begin
      #100000;
      miscompares++;
      test_done();
   end
endmodule // tb_top

bind tcc_cc_detect tcc_cc_detect_sva #(.TOGGLE_CYC(TOGGLE_CYC)) tcc_cc_detect_sva_inst (.*);

// ==== bench/tcc_cc_detect_sva.sv ====
// Concurrent checks on the ports of the CC detect and indicate block
`timescale 1ns/100ps
`include "tcc_defines.vh"

module tcc_cc_detect_sva #(
   parameter TOGGLE_CYC = 10000
) (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       chip_enable_bar,
   input wire logic [1:0] roleOverride,
   input wire logic       roleWrite,
   input wire logic       busMode,
   input wire logic [1:0] activeRole,
   input wire logic       hostRole,
   input wire logic [2:0] rpSourceEn,
   input wire logic [1:0] rpLevelSel,
   input wire logic       cableAttached,
   input wire logic       attachedSink,
   input wire logic       attachedHost,
   input wire logic [1:0] detectedCurrent,
   input wire logic [1:0] accessory,
   input wire logic [1:0] cc1Term,
   input wire logic [1:0] cc2Term,
   input wire logic       connection_detect_out,
   input wire logic       idOe_b,
   input wire logic       irqOe_b,
   input wire logic       audioOe_b,
   input wire logic       indHiOe_b,
   input wire logic       indLoOe_b
);
   // ==========
   // One domain; hibernation counts as reset
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b || chip_enable_bar);

   // Three open terms in a row leave no time for a stale status
   conn_clear_a: assert property ((cc1Term == `TCC_TERM_OPEN && cc2Term == `TCC_TERM_OPEN)[*3]
      |-> !connection_detect_out && !cableAttached) else $error("status kept without a connection");
   conn_set_a: assert property (attachedSink || attachedHost |-> connection_detect_out)
      else $error("connection detect low while attached");
   id_pull_a: assert property (hostRole && $rose(attachedSink) |-> ##[0:2] !idOe_b)
      else $error("ID pin not pulled on sink attach");
   irq_attach_a: assert property (busMode && $changed(attachedHost || attachedSink)
      |-> ##[0:3] !irqOe_b) else $error("no interrupt on attach or detach");
   irq_current_a: assert property (busMode && $changed(detectedCurrent) |-> ##[0:3] !irqOe_b)
      else $error("no interrupt on current change");
   bus_pins_a: assert property (busMode && $past(busMode) |-> indHiOe_b && indLoOe_b && audioOe_b)
      else $error("status pin pulled in bus mode");
   cur_pins_a: assert property ((!busMode && attachedHost && $stable(detectedCurrent))[*2]
      |-> {indHiOe_b, indLoOe_b} == (detectedCurrent == `TCC_CUR_HIGH ? 2'h0 :
      detectedCurrent == `TCC_CUR_MEDIUM ? 2'h2 : 2'h3)) else $error("current pins wrong");
   audio_pin_a: assert property ((!busMode && $stable(accessory))[*2]
      |-> audioOe_b == (accessory != `TCC_ACC_AUDIO)) else $error("audio pin wrong");
   rp_source_a: assert property ((hostRole && $stable(rpLevelSel))[*2]
      |-> rpSourceEn == (rpLevelSel == `TCC_CUR_MEDIUM ? 3'h2 :
      rpLevelSel == `TCC_CUR_HIGH ? 3'h4 : 3'h1)) else $error("pull-up source wrong");
   role_hold_a: assert property (busMode && $past(busMode, 3) && !$past(roleWrite)
      && !$past(roleWrite, 2) |-> $stable(activeRole)) else $error("role moved without a write");
   role_write_a: assert property (busMode && roleWrite && roleOverride != 2'h3
      |-> ##2 activeRole == $past(roleOverride, 2)) else $error("role write not taken");
endmodule // tcc_cc_detect_sva

// ==== bench/tcc_remote_port.sv ====
// Remote Type-C port model: a termination per line becomes comparator levels
`timescale 1ns/100ps

module tcc_remote_port (
   input  wire logic       hostRole,
   input  wire logic [2:0] kind1,        // 0 open,1 Ra,2 Rd,3..5 Rp default/medium/high
   input  wire logic [2:0] kind2,
   output logic            cc1BelowRa,
   output logic            cc1BelowRd,
   output logic            cc1AboveRp1,
   output logic            cc1AboveRp2,
   output logic            cc2BelowRa,
   output logic            cc2BelowRd,
   output logic            cc2AboveRp1,
   output logic            cc2AboveRp2
);
   // ==========
   // Levels {belowRa, belowRd, aboveRp1, aboveRp2} of one line
   function automatic logic [3:0] levels(input logic host, input logic [2:0] kind);
      // Our pull-up: Ra sits lowest, Rd in the sink band, open or remote Rp high
      if (host)
         return (kind == 3'd1) ? 4'hc : (kind == 3'd2) ? 4'h4 : 4'h0;
      // Our Rd: only a remote pull-up lifts the line, by its strength
      return (kind < 3'd3) ? 4'hc : (kind == 3'd4) ? 4'h2 : (kind == 3'd5) ? 4'h3 : 4'h0;
   endfunction

   // Lines follow the role at once, as a resistor divider would
   always_comb {cc1BelowRa, cc1BelowRd, cc1AboveRp1, cc1AboveRp2} = levels(hostRole, kind1);
   always_comb {cc2BelowRa, cc2BelowRd, cc2AboveRp1, cc2AboveRp2} = levels(hostRole, kind2);
endmodule // tcc_remote_port

// ==== src/tcc_cc_classify.v ====
// Per-line CC comparator classifier for host and sink roles
`timescale 1ns/100ps
`include "tcc_defines.vh"

module tcc_cc_classify (
   clk,
   rst_b,
   hostRole,
   ccBelowRa,
   ccBelowRd,
   ccAboveRp1,
   ccAboveRp2,
   term,
   rpLevel
);
   input  wire       clk;
   input  wire       rst_b;
   input  wire       hostRole;
   input  wire       ccBelowRa;   // Below the Ra ceiling of current level
   input  wire       ccBelowRd;   // Below the sink ceiling of current level
   input  wire       ccAboveRp1;  // Sink role: above medium threshold
   input  wire       ccAboveRp2;  // Sink role: above high threshold
   output reg  [1:0] term;
   output reg  [1:0] rpLevel;

   reg [1:0] next_term;
   reg [1:0] next_rpLevel;

   // ==========================================================
   // Classification
   // Thresholds are analog and level-specific; logic only sees flags
   always @* begin
      next_term    = `TCC_TERM_OPEN;
      next_rpLevel = `TCC_CUR_DEFAULT;
      if (hostRole) begin
         if (ccBelowRa)
            next_term = `TCC_TERM_RA;                          // RULE14
         else if (ccBelowRd)
            next_term = `TCC_TERM_RD;                          // RULE14
         else
            next_term = `TCC_TERM_OPEN;                        // RULE14
      end else if (!ccBelowRa) begin
         next_term = `TCC_TERM_RP;                             // RULE17
         if (ccAboveRp2)
            next_rpLevel = `TCC_CUR_HIGH;                      // RULE15
         else if (ccAboveRp1)
            next_rpLevel = `TCC_CUR_MEDIUM;                    // RULE15
      end
   end

   // Registered so downstream change detection sees clean edges
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         term    <= `TCC_TERM_OPEN;
         rpLevel <= `TCC_CUR_DEFAULT;
      end else begin
         term    <= next_term;
         rpLevel <= next_rpLevel;
      end
   end
endmodule // tcc_cc_classify

// ==== src/tcc_cc_detect.v ====
// Top of the Type-C configuration-channel detect and indicate block
`timescale 1ns/100ps
`include "tcc_defines.vh"

module tcc_cc_detect #(
   parameter TOGGLE_CYC = `TCC_TOGGLE_CYC
) (
   clk,
   rst_b,
   chip_enable_bar,
   adrStrap,
   roleStrap,
   roleOverride,
   roleWrite,
   rpSelect,
   statusAck,
   cc1BelowRa,
   cc1BelowRd,
   cc1AboveRp1,
   cc1AboveRp2,
   cc2BelowRa,
   cc2BelowRd,
   cc2AboveRp1,
   cc2AboveRp2,
   busMode,
   busAdrHigh,
   activeRole,
   hostRole,
   rpSourceEn,
   rpLevelSel,
   cableAttached,
   attachedSink,
   attachedHost,
   orientation,
   accessory,
   cc1Term,
   cc2Term,
   detectedCurrent,
   connection_detect_out,
   idOut,
   idOe_b,
   status_change_irq_n,
   irqOe_b,
   audio_accessory_flag_n,
   audioOe_b,
   source_current_ind_hi,
   indHiOe_b,
   source_current_ind_lo,
   indLoOe_b
);
   input  wire       clk;
   input  wire       rst_b;
   input  wire       chip_enable_bar;      // High: hibernate
   input  wire [1:0] adrStrap;
   input  wire [1:0] roleStrap;
   input  wire [1:0] roleOverride;
   input  wire       roleWrite;            // One-cycle role write strobe
   input  wire [1:0] rpSelect;             // Advertised current level
   input  wire       statusAck;            // Status read clears interrupt
   input  wire       cc1BelowRa;
   input  wire       cc1BelowRd;
   input  wire       cc1AboveRp1;
   input  wire       cc1AboveRp2;
   input  wire       cc2BelowRa;
   input  wire       cc2BelowRd;
   input  wire       cc2AboveRp1;
   input  wire       cc2AboveRp2;
   output wire       busMode;
   output wire       busAdrHigh;
   output reg  [1:0] activeRole;
   output reg        hostRole;
   output reg  [2:0] rpSourceEn;           // One-hot 80/180/330 uA sources
   output reg  [1:0] rpLevelSel;
   output reg        cableAttached;
   output reg        attachedSink;
   output reg        attachedHost;
   output reg  [1:0] orientation;
   output reg  [1:0] accessory;
   output wire [1:0] cc1Term;
   output wire [1:0] cc2Term;
   output reg  [1:0] detectedCurrent;
   output reg        connection_detect_out;
   output wire       idOut;
   output reg        idOe_b;
   output wire       status_change_irq_n;
   output reg        irqOe_b;
   output wire       audio_accessory_flag_n;
   output reg        audioOe_b;
   output wire       source_current_ind_hi;
   output reg        indHiOe_b;
   output wire       source_current_ind_lo;
   output reg        indLoOe_b;

   // Local reset: hibernation wipes all state
   wire        runRst_b = rst_b & ~chip_enable_bar;          // RULE6
   wire        latched;
   wire [1:0]  strapRole;
   wire [1:0]  cc1Rp;
   wire [1:0]  cc2Rp;
   reg         overridden;
   reg  [1:0]  heldRole;
   reg  [1:0]  roleSel;
   reg  [15:0] toggleCnt;
   reg         drpHostPhase;
   reg         irqPending;
   reg  [1:0]  prevCurrent;
   reg         prevConn;
   reg  [1:0]  next_accessory;
   reg  [1:0]  next_orientation;
   reg  [1:0]  next_current;
   reg         next_conn;
   reg         next_sinkSeen;
   reg         next_hostSeen;

   // Open-drain pins only ever pull low
   assign idOut                  = 1'b0;
   assign status_change_irq_n    = 1'b0;
   assign audio_accessory_flag_n = 1'b0;
   assign source_current_ind_hi  = 1'b0;
   assign source_current_ind_lo  = 1'b0;

   // ==========================================================
   // Strap capture
   tcc_strap_latch u_strap (
      .clk       (clk),
      .rst_b     (runRst_b),
      .adrStrap  (adrStrap),
      .roleStrap (roleStrap),
      .latched   (latched),
      .busMode   (busMode),
      .adrHigh   (busAdrHigh),
      .strapRole (strapRole)
   );

   // ==========================================================
   // Role selection
   // Pin mode follows the live strap; bus mode holds the latched one
   always @* begin
      if (overridden)
         roleSel = heldRole;                                   // RULE7
      else if (latched && !busMode)
         roleSel = (roleStrap == `TCC_STRAP_HIGH) ? `TCC_ROLE_HOST :
                   (roleStrap == `TCC_STRAP_LOW)  ? `TCC_ROLE_SINK :
                                                    `TCC_ROLE_DUAL; // RULE8
      else
         roleSel = strapRole;                                  // RULE21
   end

   // Override sticks until hibernation; reserved code 3 is refused
   always @(posedge clk or negedge runRst_b) begin
      if (!runRst_b) begin
         overridden <= 1'b0;
         heldRole   <= `TCC_ROLE_RESET;
         activeRole <= `TCC_ROLE_RESET;
      end else begin
         if (roleWrite && busMode && latched && roleOverride != 2'h3) begin
            overridden <= 1'b1;                                // RULE7
            heldRole   <= roleOverride;
         end
         activeRole <= roleSel;
      end
   end

   // Dual role alternates between advertising and sinking until attached
   always @(posedge clk or negedge runRst_b) begin
      if (!runRst_b) begin
         toggleCnt    <= 16'h0000;
         drpHostPhase <= 1'b0;
      end else if (activeRole != `TCC_ROLE_DUAL || cableAttached) begin
         toggleCnt <= 16'h0000;
      end else if (toggleCnt == TOGGLE_CYC[15:0] - 16'h0001) begin
         toggleCnt    <= 16'h0000;
         drpHostPhase <= ~drpHostPhase;
      end else begin
         toggleCnt <= toggleCnt + 16'h0001;
      end
   end

   // ==========================================================
   // Pull-up current source selection
   // Reserved select code falls back to default rather than no source
   always @(posedge clk or negedge runRst_b) begin
      if (!runRst_b) begin
         hostRole   <= 1'b0;
         rpLevelSel <= `TCC_CUR_RESET;                         // RULE9
         rpSourceEn <= 3'h0;
      end else begin
         hostRole   <= (activeRole == `TCC_ROLE_HOST) ||
                       (activeRole == `TCC_ROLE_DUAL && drpHostPhase);
         rpLevelSel <= (busMode && rpSelect != 2'h3) ? rpSelect
                                                     : `TCC_CUR_DEFAULT; // RULE9
         if (!hostRole)
            rpSourceEn <= 3'h0;
         else case (rpLevelSel)
            `TCC_CUR_MEDIUM: rpSourceEn <= 3'h2;                // RULE10
            `TCC_CUR_HIGH:   rpSourceEn <= 3'h4;                // RULE10
            default:         rpSourceEn <= 3'h1;                // RULE10
         endcase
      end
   end

   // ==========================================================
   // Per-line classifiers
   tcc_cc_classify u_cc1 (
      .clk        (clk),
      .rst_b      (runRst_b),
      .hostRole   (hostRole),
      .ccBelowRa  (cc1BelowRa),
      .ccBelowRd  (cc1BelowRd),
      .ccAboveRp1 (cc1AboveRp1),
      .ccAboveRp2 (cc1AboveRp2),
      .term       (cc1Term),
      .rpLevel    (cc1Rp)
   );

   tcc_cc_classify u_cc2 (
      .clk        (clk),
      .rst_b      (runRst_b),
      .hostRole   (hostRole),
      .ccBelowRa  (cc2BelowRa),
      .ccBelowRd  (cc2BelowRd),
      .ccAboveRp1 (cc2AboveRp1),
      .ccAboveRp2 (cc2AboveRp2),
      .term       (cc2Term),
      .rpLevel    (cc2Rp)
   );

   // ==========================================================
   // Pair evaluation: attach, orientation, accessory, current
   always @* begin
      next_accessory   = `TCC_ACC_NONE;
      next_orientation = `TCC_ORIENT_NONE;
      next_current     = `TCC_CUR_DEFAULT;
      next_sinkSeen    = 1'b0;
      next_hostSeen    = 1'b0;
      if (cc1Term == `TCC_TERM_RA && cc2Term == `TCC_TERM_RA)
         next_accessory = `TCC_ACC_AUDIO;                      // RULE17
      else if (cc1Term == `TCC_TERM_RD && cc2Term == `TCC_TERM_RD)
         next_accessory = `TCC_ACC_DEBUG;                      // RULE17
      else if (cc1Term == `TCC_TERM_RD) begin
         next_sinkSeen    = 1'b1;                              // RULE11
         next_orientation = `TCC_ORIENT_CC1;                   // RULE16
      end else if (cc2Term == `TCC_TERM_RD) begin
         next_sinkSeen    = 1'b1;                              // RULE11
         next_orientation = `TCC_ORIENT_CC2;                   // RULE16
      end else if (cc1Term == `TCC_TERM_RP) begin
         next_hostSeen    = 1'b1;
         next_orientation = `TCC_ORIENT_CC1;                   // RULE16
         next_current     = cc1Rp;                             // RULE15
      end else if (cc2Term == `TCC_TERM_RP) begin
         next_hostSeen    = 1'b1;
         next_orientation = `TCC_ORIENT_CC2;                   // RULE16
         next_current     = cc2Rp;                             // RULE15
      end
      next_conn = next_sinkSeen | next_hostSeen | (next_accessory != `TCC_ACC_NONE);
   end

   // Status registers; all cleared when nothing is connected
   always @(posedge clk or negedge runRst_b) begin
      if (!runRst_b) begin
         cableAttached         <= 1'b0;
         attachedSink          <= 1'b0;
         attachedHost          <= 1'b0;
         orientation           <= `TCC_ORIENT_NONE;
         accessory             <= `TCC_ACC_NONE;
         detectedCurrent       <= `TCC_CUR_DEFAULT;
         connection_detect_out <= 1'b0;
      end else begin
         cableAttached         <= next_conn;                   // RULE12
         attachedSink          <= next_sinkSeen;               // RULE11
         attachedHost          <= next_hostSeen;
         orientation           <= next_orientation;
         accessory             <= next_accessory;
         detectedCurrent       <= next_current;                // RULE15
         connection_detect_out <= next_conn;                   // RULE18 RULE19
      end
   end

   // ==========================================================
   // Change interrupt; a new event wins over a same-cycle ack
   always @(posedge clk or negedge runRst_b) begin
      if (!runRst_b) begin
         prevConn    <= 1'b0;
         prevCurrent <= `TCC_CUR_DEFAULT;
         irqPending  <= 1'b0;
      end else begin
         prevConn    <= cableAttached;
         prevCurrent <= detectedCurrent;
         if ((prevConn != cableAttached) || (prevCurrent != detectedCurrent))
            irqPending <= 1'b1;                                // RULE13
         else if (statusAck)
            irqPending <= 1'b0;
      end
   end

   // ==========================================================
   // Pin enables, low means pulling low
   // Bus mode frees the current pins for the two-wire bus
   always @(posedge clk or negedge runRst_b) begin
      if (!runRst_b) begin
         idOe_b    <= 1'b1;
         irqOe_b   <= 1'b1;
         audioOe_b <= 1'b1;
         indHiOe_b <= 1'b1;
         indLoOe_b <= 1'b1;
      end else begin
         idOe_b    <= ~(hostRole & attachedSink);              // RULE5
         irqOe_b   <= ~(busMode & irqPending);                 // RULE1
         audioOe_b <= ~(!busMode && latched &&
                        accessory == `TCC_ACC_AUDIO);          // RULE2
         indHiOe_b <= ~(!busMode && latched &&
                        detectedCurrent == `TCC_CUR_HIGH);     // RULE3 RULE4
         indLoOe_b <= ~(!busMode && latched &&
                        detectedCurrent != `TCC_CUR_DEFAULT);  // RULE3 RULE4
      end
   end
endmodule // tcc_cc_detect

// ==== src/tcc_defines.vh ====
// Constants for the Type-C configuration-channel detect and indicate block
//
// Notes on behaviour
// [RULE1] Bus mode: interrupt pin pulled low on status change, released otherwise.
// [RULE2] Pin mode: audio flag pin low when an audio accessory is found.
// [RULE3] Pin mode current pins hi,lo: 00 high, 10 medium, 11 default.
// [RULE4] Current pins serve the two-wire bus in bus mode, status outputs otherwise.
// [RULE5] ID pin low when acting as host and a valid sink is seen.
// [RULE6] Enable-bar low runs the device; high hibernates and loses register state.
// [RULE7] Role comes from the three-level role strap; a register write overrides it.
// [RULE8] With address strap mid-level, role strap changes take effect any time.
// [RULE9] Host advertised current selectable by register; default level after power-up.
// [RULE10] Three pull-up sources: default, medium 180 uA, high.
// [RULE11] Comparators watched continuously; report attached sink or powered cable.
// [RULE12] Cable-attached bit cleared whenever nothing is connected.
// [RULE13] Interrupt asserted on attach, detach and any detected source current change.
// [RULE14] Host role classifies each CC line as sink, Ra or open per level.
// [RULE15] Sink role reports advertised remote current in status and on pins.
// [RULE16] Which CC line is connected gives the plug orientation.
// [RULE17] Detect audio and debug accessories; report Ra, Rd, Rp or open per line.
// [RULE18] Connection-detect output low when no connection is present.
// [RULE19] Connection-detect output high while a connection is detected.
// [RULE20] Address strap sampled at power-up: high or low bus mode, mid pin mode.
// [RULE21] Bus mode: role strap latched once at power-up; later changes by register.
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ==========================================================
// Three-level strap codes
`define TCC_STRAP_LOW      2'h0
`define TCC_STRAP_HIGH     2'h1
`define TCC_STRAP_MID      2'h2

// ==========================================================
// Role codes, same as the mode-select field
`define TCC_ROLE_SINK      2'h0
`define TCC_ROLE_HOST      2'h1
`define TCC_ROLE_DUAL      2'h2
`define TCC_ROLE_RESET     2'h0

// ==========================================================
// Pull-up current level codes
`define TCC_CUR_DEFAULT    2'h0
`define TCC_CUR_MEDIUM     2'h1
`define TCC_CUR_HIGH       2'h2
`define TCC_CUR_RESET      2'h0
`define TCC_SRC_DEF_UA     80
`define TCC_SRC_MED_UA     180
`define TCC_SRC_HIGH_UA    330

// ==========================================================
// Per-line termination codes
`define TCC_TERM_OPEN      2'h0
`define TCC_TERM_RA        2'h1
`define TCC_TERM_RD        2'h2
`define TCC_TERM_RP        2'h3

// ==========================================================
// Orientation codes
`define TCC_ORIENT_NONE    2'h0
`define TCC_ORIENT_CC1     2'h1
`define TCC_ORIENT_CC2     2'h2

// ==========================================================
// Accessory codes
`define TCC_ACC_NONE       2'h0
`define TCC_ACC_AUDIO      2'h1
`define TCC_ACC_DEBUG      2'h2

// ==========================================================
// Timing: dual-role toggle half period and strap latch delay
`define TCC_TOGGLE_US      50
`define TCC_CLK_MHZ        200
`define TCC_TOGGLE_CYC     (`TCC_TOGGLE_US * `TCC_CLK_MHZ)
`define TCC_LATCH_NS       100
`define TCC_LATCH_CYC      ((`TCC_LATCH_NS * `TCC_CLK_MHZ) / 1000)

`endif

// ==== src/tcc_strap_latch.v ====
// Power-up latch of the address and role straps
`timescale 1ns/100ps
`include "tcc_defines.vh"

module tcc_strap_latch #(
   parameter LATCH_CYC = `TCC_LATCH_CYC
) (
   clk,
   rst_b,
   adrStrap,
   roleStrap,
   latched,
   busMode,
   adrHigh,
   strapRole
);
   input  wire       clk;
   input  wire       rst_b;
   input  wire [1:0] adrStrap;
   input  wire [1:0] roleStrap;
   output reg        latched;
   output reg        busMode;
   output reg        adrHigh;
   output reg  [1:0] strapRole;

   reg [7:0] waitCnt;

   // ==========================================================
   // Capture after release; async reset loads constants only
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         waitCnt   <= 8'h00;
         latched   <= 1'b0;
         busMode   <= 1'b0;
         adrHigh   <= 1'b0;
         strapRole <= `TCC_ROLE_RESET;
      end else if (!latched) begin
         waitCnt <= waitCnt + 8'h01;
         if (waitCnt == LATCH_CYC[7:0]) begin
            latched   <= 1'b1;
            busMode   <= (adrStrap != `TCC_STRAP_MID);      // RULE20
            adrHigh   <= (adrStrap == `TCC_STRAP_HIGH);     // RULE20
            strapRole <= (roleStrap == `TCC_STRAP_HIGH) ? `TCC_ROLE_HOST :
                         (roleStrap == `TCC_STRAP_LOW)  ? `TCC_ROLE_SINK :
                                                          `TCC_ROLE_DUAL; // RULE7
         end
      end
   end
endmodule // tcc_strap_latch
